// ==== rbx_regs.svh ====
// What this block does
// [RULE1] a taken branch loads the incremented counter plus twice the signed offset.
// [RULE2] each conditional branch is one word, one cycle when not taken and two when taken.
// [RULE3] a taken branch decodes in Q1, reads the offset in Q2, processes in Q3, writes the counter in Q4, then idles a cycle.
// [RULE4] a branch not taken decodes, reads and processes in Q1 to Q3 and only steps the counter by one word in Q4.
// [RULE5] branch_if_zero_clear is 1110 0001 with an 8-bit signed offset.
// [RULE6] branch_if_zero_clear jumps only when the zero flag is 0 and changes no flags.
// [RULE7] branch_if_overflow_clear is 1110 0101 and jumps only when the overflow flag is 0.
// [RULE8] relative_jump_always is 1101 then 0 with an 11-bit signed offset from -1024 to 1023.
// [RULE9] relative_jump_always always adds twice its offset to the incremented counter and changes no flags.
// [RULE10] relative_jump_always always takes two cycles, the second doing nothing.
// [RULE11] set_register_bit is 1000 bbba ffffffff and forces bit b of register f to one.
// [RULE12] with a equal to 0 set_register_bit addresses the access bank and ignores the bank pointer.
// [RULE13] with a equal to 1 the address is the bank_select_pointer joined to the 8-bit address.
// [RULE14] set_register_bit is one cycle: decode Q1, read Q2, modify Q3, write Q4; the code reads and modifies in Q3 and strobes the write in the next Q1.
// [RULE15] the prefetched sequential word is discarded during the extra cycle of a taken branch.
`ifndef RBX_REGS_SVH
`define RBX_REGS_SVH
`define RBX_OP_BRC 4'he
`define RBX_CC_ZERO_CLR 4'h1
`define RBX_CC_OVF_CLR 4'h5
`define RBX_OP_JMP 5'h1a
`define RBX_OP_BSET 4'h8
`define RBX_PC_RST 21'h000000
`define RBX_PC_STEP 21'h000002
`endif

// ==== rbx_pkg.sv ====
package rbx_pkg;
    typedef enum logic [3:0] {
        RBX_Q1 = 4'h1,
        RBX_Q2 = 4'h2,
        RBX_Q3 = 4'h4,
        RBX_Q4 = 4'h8
    } rbx_q_t;
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } rbx_wr_t;
endpackage

// ==== rbx_qgen.sv ====
`timescale 1ns/1ps
// quarter phase sequencer, one state per quarter
module rbx_qgen (
    input wire logic clk,
    input wire logic rst,
    output rbx_pkg::rbx_q_t q
);
    rbx_pkg::rbx_q_t q_q;
    rbx_pkg::rbx_q_t q_d;
    // next quarter
    always_comb begin
        case (q_q)
            rbx_pkg::RBX_Q1: q_d = rbx_pkg::RBX_Q2;
            rbx_pkg::RBX_Q2: q_d = rbx_pkg::RBX_Q3;
            rbx_pkg::RBX_Q3: q_d = rbx_pkg::RBX_Q4;
            default: q_d = rbx_pkg::RBX_Q1;
        endcase
    end
    // register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_q <= rbx_pkg::RBX_Q1;
        end else begin
            q_q <= q_d;
        end
    end
    assign q = q_q;
endmodule // rbx_qgen

// ==== rbx_exec.sv ====
`timescale 1ns/1ps
`include "rbx_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module rbx_exec (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [15:0] INSTR,
    input wire logic ZERO_FLAG,
    input wire logic OVF_FLAG,
    input wire logic [3:0] BANK_PTR,
    input wire logic [7:0] RD_DATA,
    output logic [20:0] PC,
    output logic [11:0] RD_ADDR,
    output logic RD_EN,
    output logic WR_EN,
    output logic [11:0] WR_ADDR,
    output logic [7:0] WR_DATA,
    output logic Q1_STROBE,
    output logic FLUSH
);
    rbx_pkg::rbx_q_t q;
    logic [15:0] ir_q, ir_d;
    logic [20:0] pc_q, pc_d;
    logic flush_q, flush_d;
    logic jump_q, jump_d;
    logic [7:0] mod_q, mod_d;
    logic [11:0] addr_q, addr_d;
    rbx_pkg::rbx_wr_t wr_q, wr_d;
    logic is_bz, is_bo, is_jmp, is_bset;
    logic [20:0] off2;
    logic [7:0] bit_mask;

    rbx_qgen u_qgen (
        .clk(MCLK),
        .rst(SYS_RST),
        .q(q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // match of the conditional branch group against one condition code
    function automatic logic cond_branch(input logic [15:0] ir, input logic [3:0] cc);
        cond_branch = (ir[15:12] == `RBX_OP_BRC) && (ir[11:8] == cc);
    endfunction

    // doubled signed offset, sign extended to the counter width
    function automatic logic [20:0] dbl_offset(input logic [15:0] ir, input logic long_off);
        if (long_off) begin
            dbl_offset = {{9{ir[10]}}, ir[10:0], 1'b0};
        end else begin
            dbl_offset = {{12{ir[7]}}, ir[7:0], 1'b0};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode of the latched word
    assign is_bz = cond_branch(ir_q, `RBX_CC_ZERO_CLR); // RULE5
    assign is_bo = cond_branch(ir_q, `RBX_CC_OVF_CLR); // RULE7
    assign is_jmp = (ir_q[15:11] == `RBX_OP_JMP); // RULE8
    assign is_bset = (ir_q[15:12] == `RBX_OP_BSET); // RULE11
    // short offset for branches, long one for the jump
    assign off2 = dbl_offset(ir_q, is_jmp); // RULE1 RULE8

    // one-hot mask of the bit that a bit-set forces
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign bit_mask[i] = (ir_q[11:9] == 3'(i)); // RULE11
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction execution per quarter
    always_comb begin
        ir_d = ir_q;
        pc_d = pc_q;
        flush_d = flush_q;
        jump_d = jump_q;
        mod_d = mod_q;
        addr_d = addr_q;
        wr_d = wr_q;
        wr_d.we = 1'b0;
        case (q)
            rbx_pkg::RBX_Q1: begin
                ir_d = INSTR; // decode
                jump_d = 1'b0;
            end
            rbx_pkg::RBX_Q2: begin
                // RULE12 RULE13 bank selection for the read
                addr_d = ir_q[8] ? {BANK_PTR, ir_q[7:0]} : {4'h0, ir_q[7:0]};
            end
            rbx_pkg::RBX_Q3: begin
                if (!flush_q) begin
                    jump_d = is_jmp || (is_bz && !ZERO_FLAG) || (is_bo && !OVF_FLAG); // RULE6 RULE7 RULE9
                    mod_d = RD_DATA | bit_mask; // RULE11
                end
            end
            default: begin
                if (flush_q) begin
                    flush_d = 1'b0; // RULE15
                    pc_d = pc_q + `RBX_PC_STEP;
                end else if (jump_q) begin
                    pc_d = pc_q + `RBX_PC_STEP + off2; // RULE1 RULE3
                    flush_d = 1'b1; // RULE2 RULE10 RULE15
                end else begin
                    pc_d = pc_q + `RBX_PC_STEP; // RULE4
                    if (is_bset) begin
                        wr_d.we = 1'b1; // RULE14
                        wr_d.addr = addr_q;
                        wr_d.data = mod_q;
                    end
                end
            end
        endcase
    end
    // state registers
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ir_q <= 16'h0000;
            pc_q <= `RBX_PC_RST;
            flush_q <= 1'b0;
            jump_q <= 1'b0;
            mod_q <= 8'h00;
            addr_q <= 12'h000;
            wr_q <= '0;
        end else begin
            ir_q <= ir_d;
            pc_q <= pc_d;
            flush_q <= flush_d;
            jump_q <= jump_d;
            mod_q <= mod_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
        end
    end

    // outputs
    assign PC = pc_q;
    assign RD_ADDR = addr_q;
    assign RD_EN = (q == rbx_pkg::RBX_Q3) && is_bset && !flush_q;
    assign WR_EN = wr_q.we;
    assign WR_ADDR = wr_q.addr;
    assign WR_DATA = wr_q.data;
    assign Q1_STROBE = (q == rbx_pkg::RBX_Q1);
    assign FLUSH = flush_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // taken branch lands on the incremented counter plus twice the offset
    AST_JUMP_TARGET: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE1
        (q == rbx_pkg::RBX_Q4 && jump_q && !flush_q) |=> (pc_q == $past(pc_q) + `RBX_PC_STEP + $past(off2)))
        else $error("bad branch target");
    // idle slot lasts exactly four quarters
    AST_TAKEN_FLUSH: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE2
        (q == rbx_pkg::RBX_Q4 && jump_q && !flush_q) |=> flush_q [*4] ##1 !flush_q)
        else $error("taken branch not two cycles");
    // no read or write during the idle slot
    AST_NOP_CYCLE: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE3
        flush_q |-> !wr_q.we && !RD_EN)
        else $error("activity in idle cycle");
    // counter moves only at the end of the fourth quarter
    AST_PC_Q4_ONLY: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE3
        (q != rbx_pkg::RBX_Q4) |=> $stable(pc_q))
        else $error("counter written outside Q4");
    // exactly one quarter active at a time
    AST_Q_ONEHOT: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE3
        $onehot(q))
        else $error("quarter phase not one-hot");
    // fall-through steps one word
    AST_NOT_TAKEN: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE4
        (q == rbx_pkg::RBX_Q4 && !jump_q && !flush_q) |=> (pc_q == $past(pc_q) + `RBX_PC_STEP) && !flush_q)
        else $error("fall-through wrong");
    // branch offset is the 8-bit field doubled
    AST_BRC_OFFSET: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE5
        (is_bz || is_bo) |-> ($signed(off2) == 21'($signed(ir_q[7:0]) * 2)))
        else $error("branch offset wrong");
    // zero condition taken only on a clear flag
    AST_ZERO_COND: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE6
        (q == rbx_pkg::RBX_Q3 && is_bz && !flush_q) |=> (jump_q == !$past(ZERO_FLAG)))
        else $error("zero branch condition");
    // overflow condition taken only on a clear flag
    AST_OVF_COND: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE7
        (q == rbx_pkg::RBX_Q3 && is_bo && !flush_q) |=> (jump_q == !$past(OVF_FLAG)))
        else $error("overflow branch condition");
    // jump offset is the 11-bit field doubled
    AST_JMP_OFFSET: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE8
        is_jmp |-> ($signed(off2) == 21'($signed(ir_q[10:0]) * 2)))
        else $error("jump offset wrong");
    // jump target whatever the flags say
    AST_JMP_ANY_FLAG: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE9
        (q == rbx_pkg::RBX_Q4 && is_jmp && !flush_q) |=> (pc_q == $past(pc_q) + `RBX_PC_STEP + $past(off2)))
        else $error("jump target wrong");
    // jump always taken and always followed by an idle slot
    AST_JMP_ALWAYS: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE10
        (q == rbx_pkg::RBX_Q3 && is_jmp && !flush_q) |=> jump_q ##1 flush_q)
        else $error("jump not taken");
    // written byte has the selected bit set
    AST_BSET_BIT: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE11
        wr_q.we |-> wr_q.data[$past(ir_q[11:9], 2)] == 1'b1)
        else $error("bit not set");
    // access bank ignores the bank pointer
    AST_ACCESS_BANK: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE12
        (wr_q.we && !ir_q[8]) |-> wr_q.addr[11:8] == 4'h0)
        else $error("access bank not used");
    // banked write uses the pointer seen in Q2
    AST_BANKED: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE13
        (wr_q.we && ir_q[8]) |-> wr_q.addr == {$past(BANK_PTR, 3), ir_q[7:0]})
        else $error("banked address wrong");
    // write decided in the fourth quarter
    AST_BSET_Q4: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE14
        wr_q.we |-> $past(q) == rbx_pkg::RBX_Q4)
        else $error("write not in Q4");
    // write strobe lasts one clock
    AST_WR_PULSE: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE14
        wr_q.we |=> !wr_q.we)
        else $error("write strobe too long");
    // idle slot only steps the counter and writes nothing
    AST_FLUSH_DISCARD: assert property (@(posedge MCLK) disable iff (SYS_RST) // RULE15
        (q == rbx_pkg::RBX_Q4 && flush_q) |=> (pc_q == $past(pc_q) + `RBX_PC_STEP) && !flush_q && !wr_q.we)
        else $error("idle slot had an effect");

    ////////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    COV_TAKEN: cover property (@(posedge MCLK) disable iff (SYS_RST) jump_q && is_bz ##1 flush_q);
    COV_JMP: cover property (@(posedge MCLK) disable iff (SYS_RST) jump_q && is_jmp);
    COV_BSET: cover property (@(posedge MCLK) disable iff (SYS_RST) wr_q.we && ir_q[8]);
    COV_ACCESS: cover property (@(posedge MCLK) disable iff (SYS_RST) wr_q.we && !ir_q[8]);
    COV_NOT_TAKEN: cover property (@(posedge MCLK) disable iff (SYS_RST)
        (q == rbx_pkg::RBX_Q4) && (is_bz || is_bo) && !jump_q && !flush_q);
endmodule // rbx_exec

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [15:0] INSTR = 16'h0000;
    logic ZERO_FLAG = 1'b0;
    logic OVF_FLAG = 1'b0;
    logic [3:0] BANK_PTR = 4'h0;
    logic [7:0] RD_DATA = 8'h00;
    logic [20:0] PC;
    logic [11:0] RD_ADDR, WR_ADDR;
    logic [7:0] WR_DATA;
    logic RD_EN, WR_EN, Q1_STROBE, FLUSH;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] seed = 32'h0000_0005;
    logic [20:0] m_pc = 21'h000000;
    logic m_flush = 1'b0;
    logic [15:0] base [4] = '{16'he100, 16'he500, 16'hd000, 16'h8000};
    logic [15:0] mask [4] = '{16'h00ff, 16'h00ff, 16'h07ff, 16'h0fff};
    ////////////////////////////////////////////////////////////////////////////////
    // free running instruction clock
    always #12.5 MCLK = ~MCLK;
    rbx_exec u_rbx_exec (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSTR(INSTR), .ZERO_FLAG(ZERO_FLAG),
        .OVF_FLAG(OVF_FLAG), .BANK_PTR(BANK_PTR), .RD_DATA(RD_DATA), .PC(PC), .RD_ADDR(RD_ADDR),
        .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .Q1_STROBE(Q1_STROBE),
        .FLUSH(FLUSH));
    ////////////////////////////////////////////////////////////////////////////////
    // xorshift source
    task automatic rnd(output logic [31:0] r);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        r = seed;
    endtask
    // one compare, counted
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one four-quarter slot against the model, entered at a falling edge
    task automatic slot(input logic [15:0] ins, input logic z, input logic v, input logic [3:0] bp,
            input logic [7:0] rd);
        logic bset, tk;
        logic [11:0] ad;
        logic [20:0] off;
        int k;
        k = 0;
        while (Q1_STROBE !== 1'b1 && k < 8) begin
            @(negedge MCLK);
            k++;
        end
        INSTR = ins;
        ZERO_FLAG = z;
        OVF_FLAG = v;
        BANK_PTR = bp;
        RD_DATA = rd;
        bset = !m_flush && ins[15:12] == 4'h8;
        tk = !m_flush && ((ins[15:8] == 8'he1 && !z) || (ins[15:8] == 8'he5 && !v) || ins[15:11] == 5'h1a);
        off = (ins[15:11] == 5'h1a) ? {{10{ins[10]}}, ins[10:0]} : {{13{ins[7]}}, ins[7:0]};
        ad = ins[8] ? {bp, ins[7:0]} : {4'h0, ins[7:0]};
        m_pc = tk ? m_pc + 21'h000002 + (off << 1) : m_pc + 21'h000002;
        repeat (2) @(negedge MCLK);
        cmp(RD_EN, bset);
        if (bset) cmp(RD_ADDR, ad);
        repeat (2) @(negedge MCLK);
        cmp(Q1_STROBE, 1'b1);
        cmp(PC, m_pc);
        cmp(FLUSH, tk);
        cmp(WR_EN, bset);
        if (bset) cmp({WR_ADDR, WR_DATA}, {ad, rd | (8'h01 << ins[11:9])});
        m_flush = tk;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // directed edges, then random mix
    initial begin
        logic [31:0] r;
        repeat (5) @(negedge MCLK);
        SYS_RST = 1'b0;
        slot(16'he17f, 1'b0, 1'b1, 4'h3, 8'h00);
        slot(16'h8f00, 1'b0, 1'b0, 4'h3, 8'h0a);
        slot(16'he180, 1'b1, 1'b0, 4'h3, 8'h00);
        slot(16'he180, 1'b0, 1'b1, 4'h3, 8'h00);
        slot(16'hd3ff, 1'b1, 1'b1, 4'h3, 8'h00);
        slot(16'he57f, 1'b0, 1'b0, 4'h3, 8'h00);
        slot(16'he580, 1'b0, 1'b0, 4'h3, 8'h00);
        slot(16'he580, 1'b0, 1'b1, 4'h3, 8'h00);
        slot(16'hd400, 1'b1, 1'b1, 4'h3, 8'h00);
        slot(16'hd3ff, 1'b1, 1'b1, 4'h3, 8'h00);
        slot(16'hd3ff, 1'b0, 1'b0, 4'h3, 8'h00);
        for (int b = 0; b < 8; b++) begin
            slot({4'h8, b[2:0], b[0], 8'ha5}, 1'b0, 1'b0, 4'hc, 8'h0a);
        end
        $display("directed slots done");
        for (int i = 0; i < 200; i++) begin
            rnd(r);
            slot(base[r[1:0]] | (r[31:16] & mask[r[1:0]]), r[2], r[3], r[7:4], r[15:8]);
        end
        $display("random slots done");
        test_done();
    end
    // hang guard, about twice the expected run
    initial begin
        #(25 * 4 * 500);
        n_fail++;
        test_done();
    end
endmodule // tb_top
